/* sanc_defines.vh */
// constants for the serial negotiation status and control bank
// assumes word indices on the bus: byte address = 4 * index
`ifndef SANC_DEFINES_VH
`define SANC_DEFINES_VH

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define SANC_IDX_PARTNER 8'h05
`define SANC_IDX_EXPAN 8'h06
`define SANC_IDX_CTRL 8'h10
`define SANC_IDX_INT_STAT 8'h20
`define SANC_IDX_INT_MASK 8'h21
`define SANC_IDX_SWRST 8'h22
`define SANC_IDX_STATUS 8'h23

// ------------------------------------------------------------
// partner ability fields
// ------------------------------------------------------------
`define SANC_PA_LINK 15
`define SANC_PA_ACK 14
`define SANC_PA_DUPLEX 12
`define SANC_PA_SPD_HI 11
`define SANC_PA_SPD_LO 10
`define SANC_PA_TXP 9
`define SANC_PA_RXP 8
`define SANC_PA_FIBER 7
`define SANC_PA_RST 16'h0000

// ------------------------------------------------------------
// expansion fields
// ------------------------------------------------------------
`define SANC_EX_LP_NP 3
`define SANC_EX_LOC_NP 2
`define SANC_EX_PAGE 1
`define SANC_EX_LP_AN 0

// ------------------------------------------------------------
// control fields and reset values
// ------------------------------------------------------------
`define SANC_CT_LOOP 12
`define SANC_CT_RSV11 11
`define SANC_CT_FORCE 10
`define SANC_CT_BYPASS 9
`define SANC_CT_RSV8 8
`define SANC_CT_RSV_HI 5
`define SANC_CT_RSV_LO 2
`define SANC_CT_MODE 0
`define SANC_RST_BYPASS 1'b1
`define SANC_RST_RSV52 4'h1
`define SANC_STRAP_MEDIA 3'b101

// ------------------------------------------------------------
// events, soft reset, status
// ------------------------------------------------------------
`define SANC_EV_PAGE 0
`define SANC_EV_LDOWN 1
`define SANC_EV_ANABLE 2
`define SANC_NUM_EV 3
`define SANC_SWRST_BIT 0
`define SANC_ST_MEDIA 0
`define SANC_ST_BYPASS 1
`define SANC_ST_LINK 2
`define SANC_ST_STRAP 3
`define SANC_STRAP_WAIT 2'h2

`endif

/* sanc_sync.v */
// two flip-flop synchroniser for levels from outside the clock domain
// assumes each bit may change independently of the others
`timescale 1ns/1ns
module sanc_sync
#(
  parameter W = 1
)
(
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

reg [W-1:0] meta_q;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    meta_q <= {W{1'b0}};
    q <= {W{1'b0}};
  end
  else
  begin
    meta_q <= d;
    q <= meta_q;
  end
end

endmodule

/* sanc_ahb.v */
// ahb-lite slave front end: decodes transfers into word index strobes
// assumes a single master, word transfers; reads take one wait state
`timescale 1ns/1ns
module sanc_ahb
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [15:0] rd_data,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  output wire wr_en,
  output wire rd_en,
  output reg [7:0] idx_q
);

reg wr_pend_q;
reg rd_wait_q;
wire acc;

// the wait state lets a write that ends just before a read land first
assign acc = hsel & htrans[1] & hready;
assign hreadyout = ~rd_wait_q;
assign hresp = 1'b0;
assign wr_en = wr_pend_q;
assign rd_en = rd_wait_q;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    wr_pend_q <= 1'b0;
    rd_wait_q <= 1'b0;
    idx_q <= 8'h00;
    hrdata <= 32'h00000000;
  end
  else
  begin
    wr_pend_q <= acc & hwrite;
    rd_wait_q <= acc & ~hwrite;
    if (acc)
    begin
      idx_q <= haddr[9:2];
    end
    if (rd_wait_q)
    begin
      hrdata <= {16'h0000, rd_data};
    end
  end
end

endmodule

/* sanc_top.v */
// serial negotiation status and control register bank
// assumes link, sync and page inputs come from logic on hclk;
// the mode strap comes from pins and is synchronised here.
//
// Summary of operation
// RULE1 - in media mode, clear partner fields on link down, load on base page
// RULE2 - partner bit 15 mirrors code word bit 15, partner copper link up
// RULE3 - partner bit 14 mirrors code word bit 14, acknowledge
// RULE4 - partner bit 12 mirrors code word bit 12, full duplex capable
// RULE5 - partner bits 11:10 mirror code word speed field
// RULE6 - bits 9,8,7 pause and media, nonzero only with enhanced partner
// RULE7 - expansion bit 3 shows partner next page ability
// RULE8 - expansion bit 2 is read-only local next page ability
// RULE9 - expansion bit 1 latches high when a valid page arrives
// RULE10 - expansion bit 0 set on sync, three matching groups, negotiation on
// RULE11 - control bit 12 loops serial input back to serial output
// RULE12 - control bit 10 forces the serial link up
// RULE13 - control bit 9 resets to one and allows negotiation bypass
// RULE14 - bypass and mode writes take effect only at soft reset
// RULE15 - mode bit defaults to one when strap is 101 at hardware reset
// RULE16 - mode bit zero selects system mode, one media mode
// RULE17 - reading expansion clears page received; a new page sets it
// RULE18 - reserved read-only fields read reset values and ignore writes; control bits 11, 8 and 5:2 here take writes and read them back
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "sanc_defines.vh"
module sanc_top
#(
  parameter LOCAL_NP_ABLE = 1'b0
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire [2:0] mode_strap,
  input wire link_up,
  input wire rx_page_valid,
  input wire rx_base_page,
  input wire [15:0] rx_code_word,
  input wire rx_next_page,
  input wire lp_enhanced,
  input wire sync_ok,
  input wire cfg_match3,
  input wire an_enable,
  output wire loopback_en,
  output wire force_link_good,
  output wire link_up_eff,
  output wire bypass_allowed,
  output wire media_mode,
  output wire irq
);

// ------------------------------------------------------------
// bus front end
// ------------------------------------------------------------
wire wr_en;
wire rd_en;
wire [7:0] idx_q;
reg [15:0] rd_data;

sanc_ahb u_ahb
(
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .rd_data(rd_data),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .wr_en(wr_en),
  .rd_en(rd_en),
  .idx_q(idx_q)
);

// hsize is not decoded: every access is treated as a whole word
function hit;
  input [7:0] idx;
  input [7:0] want;
  begin
    hit = (idx == want);
  end
endfunction

wire wr_ctrl;
wire wr_stat;
wire wr_mask;
wire swrst;
wire rd_expan;

assign wr_ctrl = wr_en & hit(idx_q, `SANC_IDX_CTRL);
assign wr_stat = wr_en & hit(idx_q, `SANC_IDX_INT_STAT);
assign wr_mask = wr_en & hit(idx_q, `SANC_IDX_INT_MASK);
assign swrst = wr_en & hit(idx_q, `SANC_IDX_SWRST) & hwdata[`SANC_SWRST_BIT];
assign rd_expan = rd_en & hit(idx_q, `SANC_IDX_EXPAN);

// ------------------------------------------------------------
// strap capture
// ------------------------------------------------------------
wire [2:0] strap_s;
reg [1:0] strap_cnt_q;
reg strap_done_q;
wire strap_load;

sanc_sync #(.W(3)) u_strap_sync
(
  .hclk(hclk),
  .hresetn(hresetn),
  .d(mode_strap),
  .q(strap_s)
);

// the synchroniser needs two edges after release before it shows the pins
assign strap_load = ~strap_done_q & (strap_cnt_q == `SANC_STRAP_WAIT);

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    strap_cnt_q <= 2'h0;
    strap_done_q <= 1'b0;
  end
  else if (!strap_done_q)
  begin
    strap_cnt_q <= strap_cnt_q + 2'h1;
    if (strap_load)
    begin
      strap_done_q <= 1'b1;
    end
  end
end

// ------------------------------------------------------------
// control register
// ------------------------------------------------------------
reg loop_q;
reg force_q;
reg bypass_q;
reg mode_q;
reg bypass_eff_q;
reg mode_eff_q;
reg rsv11_q;
reg rsv8_q;
reg [3:0] rsv52_q;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    loop_q <= 1'b0;
    force_q <= 1'b0;
    bypass_q <= `SANC_RST_BYPASS; // RULE13
    mode_q <= 1'b0;
    bypass_eff_q <= `SANC_RST_BYPASS; // RULE13
    mode_eff_q <= 1'b0;
    rsv11_q <= 1'b0;
    rsv8_q <= 1'b0;
    rsv52_q <= `SANC_RST_RSV52;
  end
  else
  begin
    if (strap_load)
    begin
      mode_q <= (strap_s == `SANC_STRAP_MEDIA); // RULE15
      mode_eff_q <= (strap_s == `SANC_STRAP_MEDIA); // RULE15
    end
    if (wr_ctrl)
    begin
      loop_q <= hwdata[`SANC_CT_LOOP];
      force_q <= hwdata[`SANC_CT_FORCE];
      bypass_q <= hwdata[`SANC_CT_BYPASS];
      mode_q <= hwdata[`SANC_CT_MODE];
      rsv11_q <= hwdata[`SANC_CT_RSV11];
      rsv8_q <= hwdata[`SANC_CT_RSV8];
      rsv52_q <= hwdata[`SANC_CT_RSV_HI:`SANC_CT_RSV_LO];
    end
    if (swrst)
    begin
      // disruptive fields move to the active copy only here
      bypass_eff_q <= bypass_q; // RULE14
      mode_eff_q <= mode_q; // RULE14
      loop_q <= 1'b0;
    end
  end
end

assign loopback_en = loop_q; // RULE11
assign force_link_good = force_q;
assign link_up_eff = force_q | link_up; // RULE12
assign bypass_allowed = bypass_eff_q; // RULE13
assign media_mode = mode_eff_q; // RULE16

// ------------------------------------------------------------
// partner ability (media mode layout)
// ------------------------------------------------------------
reg [15:0] pa_q;
wire base_in;
wire [2:0] enh_bits;

assign base_in = rx_page_valid & rx_base_page & mode_eff_q;
// pause and media bits mean nothing from a plain partner
assign enh_bits = rx_code_word[`SANC_PA_TXP:`SANC_PA_FIBER] & {3{lp_enhanced}};

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    pa_q <= `SANC_PA_RST;
  end
  else if (swrst | ~mode_eff_q)
  begin
    pa_q <= `SANC_PA_RST;
  end
  else if (!link_up_eff)
  begin
    pa_q <= `SANC_PA_RST; // RULE1
  end
  else if (base_in)
  begin
    pa_q <= `SANC_PA_RST; // RULE1
    pa_q[`SANC_PA_LINK] <= rx_code_word[`SANC_PA_LINK]; // RULE2
    pa_q[`SANC_PA_ACK] <= rx_code_word[`SANC_PA_ACK]; // RULE3
    pa_q[`SANC_PA_DUPLEX] <= rx_code_word[`SANC_PA_DUPLEX]; // RULE4
    pa_q[`SANC_PA_SPD_HI:`SANC_PA_SPD_LO] <= rx_code_word[`SANC_PA_SPD_HI:`SANC_PA_SPD_LO]; // RULE5
    pa_q[`SANC_PA_TXP:`SANC_PA_FIBER] <= enh_bits; // RULE6
  end
end

// ------------------------------------------------------------
// negotiation expansion
// ------------------------------------------------------------
reg lp_np_q;
reg page_q;
reg lp_an_q;
wire lp_an_set;

assign lp_an_set = sync_ok & cfg_match3 & an_enable;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    lp_np_q <= 1'b0;
    page_q <= 1'b0;
    lp_an_q <= 1'b0;
  end
  else if (swrst)
  begin
    lp_np_q <= 1'b0;
    page_q <= 1'b0;
    lp_an_q <= 1'b0;
  end
  else
  begin
    if (!link_up_eff)
    begin
      lp_np_q <= 1'b0;
    end
    else if (rx_page_valid)
    begin
      lp_np_q <= rx_next_page; // RULE7
    end
    // a page arriving in the reading cycle survives the clear
    if (rx_page_valid)
    begin
      page_q <= 1'b1; // RULE9
    end
    else if (rd_expan)
    begin
      page_q <= 1'b0; // RULE17
    end
    if (lp_an_set)
    begin
      lp_an_q <= 1'b1; // RULE10
    end
    else if (!sync_ok | !an_enable)
    begin
      lp_an_q <= 1'b0; // RULE10
    end
  end
end

// ------------------------------------------------------------
// interrupts
// ------------------------------------------------------------
reg link_d1_q;
reg lp_an_d1_q;
reg [`SANC_NUM_EV-1:0] ist_q;
reg [`SANC_NUM_EV-1:0] imask_q;
wire [`SANC_NUM_EV-1:0] ev;

assign ev[`SANC_EV_PAGE] = rx_page_valid;
assign ev[`SANC_EV_LDOWN] = link_d1_q & ~link_up_eff;
assign ev[`SANC_EV_ANABLE] = lp_an_q & ~lp_an_d1_q;

always @(posedge hclk or negedge hresetn)
begin
  if (!hresetn)
  begin
    link_d1_q <= 1'b0;
    lp_an_d1_q <= 1'b0;
    imask_q <= {`SANC_NUM_EV{1'b0}};
  end
  else
  begin
    link_d1_q <= link_up_eff;
    lp_an_d1_q <= lp_an_q;
    if (wr_mask)
    begin
      imask_q <= hwdata[`SANC_NUM_EV-1:0];
    end
  end
end

genvar gi;
generate
  for (gi = 0; gi < `SANC_NUM_EV; gi = gi + 1)
  begin : g_ist
    always @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        ist_q[gi] <= 1'b0;
      end
      else if (ev[gi])
      begin
        ist_q[gi] <= 1'b1;
      end
      else if (wr_stat & hwdata[gi])
      begin
        ist_q[gi] <= 1'b0;
      end
    end
  end
endgenerate

assign irq = |(ist_q & imask_q);

// ------------------------------------------------------------
// read mux
// ------------------------------------------------------------
always @*
begin
  rd_data = 16'h0000;
  case (idx_q)
    `SANC_IDX_PARTNER:
    begin
      rd_data = pa_q; // RULE18
    end
    `SANC_IDX_EXPAN:
    begin
      rd_data[`SANC_EX_LP_NP] = lp_np_q; // RULE7
      rd_data[`SANC_EX_LOC_NP] = LOCAL_NP_ABLE; // RULE8
      rd_data[`SANC_EX_PAGE] = page_q; // RULE9
      rd_data[`SANC_EX_LP_AN] = lp_an_q; // RULE10
    end
    `SANC_IDX_CTRL:
    begin
      rd_data[`SANC_CT_LOOP] = loop_q;
      rd_data[`SANC_CT_RSV11] = rsv11_q;
      rd_data[`SANC_CT_FORCE] = force_q;
      rd_data[`SANC_CT_BYPASS] = bypass_q;
      rd_data[`SANC_CT_RSV8] = rsv8_q;
      rd_data[`SANC_CT_RSV_HI:`SANC_CT_RSV_LO] = rsv52_q;
      rd_data[`SANC_CT_MODE] = mode_q;
    end
    `SANC_IDX_INT_STAT:
    begin
      rd_data[`SANC_NUM_EV-1:0] = ist_q;
    end
    `SANC_IDX_INT_MASK:
    begin
      rd_data[`SANC_NUM_EV-1:0] = imask_q;
    end
    `SANC_IDX_STATUS:
    begin
      rd_data[`SANC_ST_MEDIA] = mode_eff_q;
      rd_data[`SANC_ST_BYPASS] = bypass_eff_q;
      rd_data[`SANC_ST_LINK] = link_up_eff;
      rd_data[`SANC_ST_STRAP] = strap_done_q;
    end
    default:
    begin
      rd_data = 16'h0000;
    end
  endcase
end

endmodule

/* sanc_top_sva.sv */
// checker for the serial negotiation register bank, bound to sanc_top
// assumes one ahb master whose hready is the bank's own hreadyout
`timescale 1ns/1ns
`include "sanc_defines.vh"
module sanc_top_sva
#(
  parameter LOCAL_NP_ABLE = 1'b0
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire [2:0] mode_strap,
  input wire loopback_en,
  input wire force_link_good,
  input wire link_up_eff,
  input wire bypass_allowed,
  input wire media_mode
);
  // ----
  // write tracking and strap counter
  // ----
  reg aw_q;
  reg [7:0] ai_q;
  reg [1:0] rc_q;
  wire rd_go = hsel && htrans[1] && hready && !hwrite;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      aw_q <= 1'b0;
      ai_q <= 8'h00;
      rc_q <= 2'h0;
    end
    else
    begin
      if (hready)
      begin
        aw_q <= hsel && htrans[1] && hwrite;
        ai_q <= haddr[9:2];
      end
      // saturates so the strap check fires once per reset
      if (rc_q != 2'h3)
        rc_q <= rc_q + 2'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // properties
  // ----
  a_force: assert property (p_force) else $error("forced link not up");
  property p_force;
    force_link_good |-> link_up_eff;
  endproperty
  a_ctl: assert property (p_ctl) else $error("control write not applied");
  property p_ctl;
    aw_q && hready && ai_q == `SANC_IDX_CTRL |=> loopback_en == $past(hwdata[`SANC_CT_LOOP])
      && force_link_good == $past(hwdata[`SANC_CT_FORCE]);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed without soft reset");
  property p_hold;
    aw_q && hready && ai_q == `SANC_IDX_CTRL |=> $stable(media_mode) && $stable(bypass_allowed);
  endproperty
  a_swrst: assert property (p_swrst) else $error("loopback kept over soft reset");
  property p_swrst;
    aw_q && hready && ai_q == `SANC_IDX_SWRST && hwdata[0] |=> !loopback_en;
  endproperty
  a_strap: assert property (p_strap) else $error("wrong mode after reset");
  property p_strap;
    rc_q == 2'h2 |=> media_mode == (mode_strap == `SANC_STRAP_MEDIA) && bypass_allowed;
  endproperty
  a_wait: assert property (p_wait) else $error("read wait state wrong");
  property p_wait;
    rd_go |=> !hreadyout ##1 hreadyout;
  endproperty
  a_exp: assert property (p_exp) else $error("expansion fixed bits wrong");
  property p_exp;
    rd_go && haddr[9:2] == `SANC_IDX_EXPAN |=> ##1 hrdata[31:4] == 28'h0 && hrdata[2] == LOCAL_NP_ABLE;
  endproperty
  a_sys: assert property (p_sys) else $error("partner word in system mode");
  property p_sys;
    rd_go && haddr[9:2] == `SANC_IDX_PARTNER && !media_mode |=> ##1 hrdata == 32'h0;
  endproperty
  a_down: assert property (p_down) else $error("partner word kept on link down");
  property p_down;
    rd_go && haddr[9:2] == `SANC_IDX_PARTNER && !link_up_eff |=> ##1 hrdata == 32'h0;
  endproperty
endmodule
bind sanc_top sanc_top_sva #(.LOCAL_NP_ABLE(LOCAL_NP_ABLE)) i_sanc_top_sva (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .mode_strap(mode_strap), .loopback_en(loopback_en),
  .force_link_good(force_link_good), .link_up_eff(link_up_eff), .bypass_allowed(bypass_allowed),
  .media_mode(media_mode));

/* sanc_far_model.sv */
// model of the link logic and the far serial device feeding the bank
// assumes the bench calls its tasks one at a time, just after a rising edge
`timescale 1ns/1ns
module sanc_far_model
(
  input wire hclk,
  output logic link_up = 1'b0,
  output logic rx_page_valid = 1'b0,
  output logic rx_base_page = 1'b0,
  output logic [15:0] rx_code_word = 16'h0000,
  output logic rx_next_page = 1'b0,
  output logic lp_enhanced = 1'b0,
  output logic sync_ok = 1'b0,
  output logic cfg_match3 = 1'b0
);
  // ----
  // far side actions
  // ----
  // word lines are inverted outside the valid pulse so stale data never matches
  task page(input logic [15:0] w, input logic base, input logic np, input logic enh);
    @(posedge hclk);
    rx_page_valid <= 1'b1;
    rx_code_word <= w;
    rx_base_page <= base;
    rx_next_page <= np;
    lp_enhanced <= enh;
    @(posedge hclk);
    rx_page_valid <= 1'b0;
    rx_code_word <= ~w;
    rx_next_page <= ~np;
    lp_enhanced <= ~enh;
  endtask
  task link(input logic v);
    @(posedge hclk);
    link_up <= v;
  endtask
  task lock(input logic v);
    @(posedge hclk);
    sync_ok <= v;
    cfg_match3 <= v;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the serial negotiation register bank
// assumes the checker is bound in and the far side is sanc_far_model
`timescale 1ns/1ns
`include "sanc_defines.vh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  // bus and side inputs get their idle values in hw_reset, while reset is held
  logic hsel;
  logic hwrite;
  logic an_enable;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] mode_strap;
  logic [31:0] d;
  wire hreadyout, hresp, link_up, rx_page_valid, rx_base_page, rx_next_page, lp_enhanced, sync_ok, cfg_match3;
  wire loopback_en, force_link_good, link_up_eff, bypass_allowed, media_mode, irq;
  wire [31:0] hrdata;
  wire [15:0] rx_code_word;
  int bad_count = 0;
  int check_count = 0;
  always #50 hclk = ~hclk;
  sanc_top i_sanc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mode_strap(mode_strap), .link_up(link_up), .rx_page_valid(rx_page_valid),
    .rx_base_page(rx_base_page), .rx_code_word(rx_code_word), .rx_next_page(rx_next_page),
    .lp_enhanced(lp_enhanced), .sync_ok(sync_ok), .cfg_match3(cfg_match3), .an_enable(an_enable),
    .loopback_en(loopback_en), .force_link_good(force_link_good), .link_up_eff(link_up_eff),
    .bypass_allowed(bypass_allowed), .media_mode(media_mode), .irq(irq));
  sanc_far_model i_sanc_far_model (.hclk(hclk), .link_up(link_up), .rx_page_valid(rx_page_valid),
    .rx_base_page(rx_base_page), .rx_code_word(rx_code_word), .rx_next_page(rx_next_page),
    .lp_enhanced(lp_enhanced), .sync_ok(sync_ok), .cfg_match3(cfg_match3));
  // ----
  // bus and compare tasks
  // ----
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask
  // hready is looked at on the falling edge, where it has settled for the next rise
  task wt(output logic [31:0] rd);
    int n;
    n = 0;
    do
    begin
      @(negedge hclk);
      rd = hrdata;
      n++;
    end
    while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20)
      chk("hreadyout", 32'h0, 32'h1);
    @(posedge hclk);
  endtask
  task xfer(input logic w, input logic [7:0] i, input logic [15:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, i, 2'h0};
    wt(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    wt(d);
  endtask
  task rdchk(input string n, input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 16'h0);
    chk(n, d, e);
    chk("hresp", 32'(hresp), 32'h0);
  endtask
  task hw_reset(input logic [2:0] s);
    int n;
    @(posedge hclk);
    hresetn <= 1'b0;
    mode_strap <= s;
    hsel <= 1'b0;
    hwrite <= 1'b0;
    hsize <= 3'h2;
    htrans <= 2'h0;
    haddr <= 32'h0;
    hwdata <= 32'h0;
    an_enable <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    do
    begin
      xfer(1'b0, `SANC_IDX_STATUS, 16'h0);
      n++;
    end
    while (d[`SANC_ST_STRAP] !== 1'b1 && n < 10);
  endtask
  // ----
  // scenarios
  // ----
  task t_defaults;
    hw_reset(3'h0);
    chk("media_mode", 32'(media_mode), 32'h0);
    chk("bypass_allowed", 32'(bypass_allowed), 32'h1);
    rdchk("ctrl", `SANC_IDX_CTRL, 32'h0204);
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h0);
    rdchk("unmapped", 8'h0f, 32'h0);
    rdchk("partner", `SANC_IDX_PARTNER, 32'h0);
    $display("test defaults done");
  endtask
  task t_media;
    hw_reset(3'h5);
    chk("media_mode", 32'(media_mode), 32'h1);
    rdchk("ctrl", `SANC_IDX_CTRL, 32'h0205);
    i_sanc_far_model.link(1'b1);
    i_sanc_far_model.page(16'hffff, 1'b1, 1'b1, 1'b1);
    rdchk("partner", `SANC_IDX_PARTNER, 32'hdf80);
    i_sanc_far_model.page(16'hffff, 1'b1, 1'b0, 1'b0);
    rdchk("partner", `SANC_IDX_PARTNER, 32'hdc00);
    for (int i = 0; i < 4; i++)
    begin
      i_sanc_far_model.page({4'h0, 2'(i), 10'h0}, 1'b1, 1'b0, 1'b0);
      rdchk("speed", `SANC_IDX_PARTNER, {20'h0, 2'(i), 10'h0});
    end
    i_sanc_far_model.page(16'h9000, 1'b0, 1'b0, 1'b0);
    xfer(1'b1, `SANC_IDX_PARTNER, 16'hffff);
    rdchk("partner", `SANC_IDX_PARTNER, 32'h0c00);
    i_sanc_far_model.link(1'b0);
    rdchk("partner", `SANC_IDX_PARTNER, 32'h0);
    i_sanc_far_model.link(1'b1);
    $display("test media done");
  endtask
  task t_expansion;
    i_sanc_far_model.page(16'h8000, 1'b1, 1'b1, 1'b1);
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h000a);
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h0008);
    i_sanc_far_model.lock(1'b1);
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h0008);
    an_enable <= 1'b1;
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h0009);
    i_sanc_far_model.lock(1'b0);
    rdchk("expansion", `SANC_IDX_EXPAN, 32'h0008);
    $display("test expansion done");
  endtask
  task t_ctrl;
    xfer(1'b1, `SANC_IDX_CTRL, 16'h1d3c);
    @(negedge hclk);
    chk("loopback_en", 32'(loopback_en), 32'h1);
    chk("media_mode", 32'(media_mode), 32'h1);
    chk("bypass_allowed", 32'(bypass_allowed), 32'h1);
    rdchk("ctrl", `SANC_IDX_CTRL, 32'h1d3c);
    i_sanc_far_model.link(1'b0);
    @(negedge hclk);
    chk("link_up_eff", 32'(link_up_eff), 32'h1);
    xfer(1'b1, `SANC_IDX_SWRST, 16'h0001);
    @(negedge hclk);
    chk("media_mode", 32'(media_mode), 32'h0);
    chk("bypass_allowed", 32'(bypass_allowed), 32'h0);
    chk("loopback_en", 32'(loopback_en), 32'h0);
    rdchk("ctrl", `SANC_IDX_CTRL, 32'h0d3c);
    xfer(1'b1, `SANC_IDX_CTRL, 16'h0000);
    @(negedge hclk);
    chk("link_up_eff", 32'(link_up_eff), 32'h0);
    $display("test ctrl done");
  endtask
  task t_irq;
    // page, link fall and negotiation-able rise have all happened by now
    rdchk("int_stat", `SANC_IDX_INT_STAT, 32'h7);
    xfer(1'b1, `SANC_IDX_INT_MASK, 16'h0000);
    xfer(1'b1, `SANC_IDX_INT_STAT, 16'h0007);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h0);
    rdchk("int_stat", `SANC_IDX_INT_STAT, 32'h0);
    i_sanc_far_model.page(16'h0000, 1'b1, 1'b0, 1'b0);
    xfer(1'b1, `SANC_IDX_INT_MASK, 16'h0001);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h1);
    xfer(1'b1, `SANC_IDX_INT_MASK, 16'h0000);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h0);
    xfer(1'b1, `SANC_IDX_INT_MASK, 16'h0001);
    xfer(1'b1, `SANC_IDX_INT_STAT, 16'h0001);
    @(negedge hclk);
    chk("irq", 32'(irq), 32'h0);
    $display("test irq done");
  endtask
  // ----
  // run control
  // ----
  task final_report;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    t_defaults();
    t_media();
    t_expansion();
    t_ctrl();
    t_irq();
    final_report();
  end
  // the whole run needs about a hundred and fifty cycles; this allows far more
  initial
  begin
    #(100 * 20000);
    bad_count++;
    final_report();
  end
endmodule
